// >>> logic/power_mode_controller.sv
// Purpose: sequences full-on, active, sleep, deep sleep and hibernate
// Assumes: all inputs synchronous to clk; requests are one-cycle pulses
// Notes: clock enables stand for the clock gates; pll_bypass selects input clock
`timescale 1ns/1ps
module power_mode_controller
  import pmc_pkg::*;
#(
  parameter int settle_cycles = power_good_settle_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic aon_rst,
  input wire logic req_active,
  input wire logic req_full_on,
  input wire logic req_sleep,
  input wire logic req_deep_sleep,
  input wire logic req_hibernate,
  input wire logic pll_enable_wr,
  input wire logic pll_enable_data,
  input wire logic pll_skip_wr,
  input wire logic pll_skip_data,
  input wire logic mult_wr,
  input wire logic [mult_width-1:0] mult_data,
  input wire logic vr_wr,
  input wire logic [vr_width-1:0] vr_data,
  input wire logic wakeup_event,
  input wire logic rtc_async_irq,
  input wire logic rtc_wake,
  input wire logic reset_pin_n,
  input wire logic phy_interrupt_wake_pin_n,
  input wire logic eth_wake_req,
  input wire logic power_good_input_n,
  output logic core_clock_en,
  output logic system_clock_en,
  output logic pll_enable,
  output logic pll_bypass,
  output logic [mult_width-1:0] pll_mult,
  output logic dma_l1_allow,
  output logic async_access_block,
  output logic core_power_on,
  output logic external_regulator_wake,
  output logic pins_tristate,
  output logic sdram_self_refresh,
  output logic core_reset,
  output logic [2:0] mode_status,
  output logic [vr_width-1:0] regulator_control_register
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mode_type mode_q, mode_d;
  logic pll_en_q;
  logic pll_skip_q;
  logic [mult_width-1:0] mult_pend_q;
  logic [mult_width-1:0] mult_q;
  logic [vr_width-1:0] vr_q;
  logic [$clog2(settle_cycles+1)-1:0] settle_q;
  logic wake_hit;
  logic sr_hold_q;

  function automatic logic [2:0] mode_code(input mode_type m);
    logic [2:0] c;
    c = mode_code_full_on;
    unique case (m)
      st_full_on: c = mode_code_full_on;
      st_active: c = mode_code_active;
      st_sleep: c = mode_code_sleep;
      st_deep_sleep: c = mode_code_deep_sleep;
      st_hibernate: c = mode_code_hibernate;
      st_power_wait: c = mode_code_power_wait;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // retained regulator control register
  // ----------------------------------------------------------------------
  pmc_retained_reg #(
    .width(vr_width),
    .reset_value(vr_reset_value)
  ) u_vr (
    .clk(clk),
    .aon_rst(aon_rst),
    .wr_en(vr_wr),
    .wr_data(vr_data),
    .value_q(vr_q)
  );

  // hibernate wake sources, each enabled in the retained register
  // limitation: the ethernet request has no enable bit and always wakes
  assign wake_hit =
    (vr_q[vr_wake_phy_bit] && !phy_interrupt_wake_pin_n) ||
    (vr_q[vr_wake_rtc_bit] && rtc_wake) ||
    (vr_q[vr_wake_reset_bit] && !reset_pin_n);

  // ----------------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------------
  // illegal requests are dropped, never queued for a later mode
  // priority: hibernate, deep sleep, sleep or full-on, active
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      st_full_on: begin
        if (req_hibernate) begin
          mode_d = st_hibernate;
        end else if (req_deep_sleep) begin
          mode_d = st_deep_sleep;
        end else if (req_sleep && pll_en_q) begin
          mode_d = st_sleep;
        end else if (req_active) begin
          mode_d = st_active;
        end
      end
      st_active: begin
        if (req_hibernate) begin
          mode_d = st_hibernate;
        end else if (req_deep_sleep) begin
          mode_d = st_deep_sleep;
        end else if ((req_full_on || req_sleep) && !pll_en_q) begin
          mode_d = st_active; // pll must be re-enabled first
        end else if (req_full_on) begin
          mode_d = st_full_on;
        end else if (req_sleep) begin
          mode_d = st_sleep;
        end
      end
      st_sleep: begin
        if (wakeup_event) begin
          mode_d = pll_skip_q ? st_active : st_full_on;
        end
      end
      st_deep_sleep: begin
        // reset pin wins over rtc when both arrive together
        if (!reset_pin_n) begin
          mode_d = st_full_on;
        end else if (rtc_async_irq) begin
          mode_d = st_active;
        end
      end
      st_hibernate: begin
        if (wake_hit || eth_wake_req) begin
          mode_d = st_power_wait;
        end
      end
      st_power_wait: begin
        // a supply that sags on the last count must not start the core
        if (!power_good_input_n &&
            settle_q == settle_cycles[$bits(settle_q)-1:0]) begin
          mode_d = st_full_on;
        end
      end
    endcase
  end

  // reset lands in full-on, the power-up default
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= st_full_on;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------------
  // power-good settle counter
  // ----------------------------------------------------------------------
  // power good must be held low for the settle count
  // trade-off: one glitch on power good restarts the whole count
  always_ff @(posedge clk) begin
    if (rst || mode_q != st_power_wait || power_good_input_n) begin
      settle_q <= '0;
    end else if (settle_q != settle_cycles[$bits(settle_q)-1:0]) begin
      settle_q <= settle_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // pll control: core registers, lost across hibernate
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || mode_q == st_hibernate) begin
      pll_en_q <= 1'b1;
      pll_skip_q <= 1'b0;
    end else begin
      if (pll_enable_wr && mode_q == st_active) begin
        pll_en_q <= pll_enable_data; // only active may turn it off
      end else if (pll_enable_wr && pll_enable_data) begin
        pll_en_q <= 1'b1;
      end
      if (pll_skip_wr) begin
        pll_skip_q <= pll_skip_data;
      end
    end
  end

  // multiplier: written value waits, applied on entry to full-on, or at once while in full-on
  // a write on the entry edge itself is applied at once
  always_ff @(posedge clk) begin
    if (rst || mode_q == st_hibernate) begin
      mult_pend_q <= mult_reset_value;
      mult_q <= mult_reset_value;
    end else begin
      if (mult_wr) begin
        mult_pend_q <= mult_data;
      end
      if (mode_d == st_full_on && mode_q != st_full_on) begin
        mult_q <= mult_wr ? mult_data : mult_pend_q;
      end else if (mult_wr && mode_q == st_full_on) begin
        mult_q <= mult_data;
      end
    end
  end

  // sdram self-refresh hold: set on hibernate entry, kept through reset wait
  // release trails full-on by two edges, once the memory side is out of reset
  always_ff @(posedge clk) begin
    if (aon_rst) begin
      sr_hold_q <= 1'b0;
    end else if (mode_q != st_hibernate && mode_d == st_hibernate) begin
      sr_hold_q <= vr_q[vr_sdram_cke_low_bit];
    end else if (mode_q == st_full_on && !rst) begin
      sr_hold_q <= 1'b0; // released once the reset sequence has finished
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  // decoded from mode_d so every output moves on the same edge as mode_q
  always_ff @(posedge clk) begin
    if (rst) begin
      core_clock_en <= 1'b1;
      system_clock_en <= 1'b1;
      pll_enable <= 1'b1;
      pll_bypass <= 1'b0;
      dma_l1_allow <= 1'b1;
      async_access_block <= 1'b0;
      core_power_on <= 1'b1;
      pins_tristate <= 1'b0;
      core_reset <= 1'b1;
      mode_status <= mode_code_full_on;
    end else begin
      core_clock_en <= mode_d inside {st_full_on, st_active};
      system_clock_en <= mode_d inside {st_full_on, st_active, st_sleep};
      pll_enable <= mode_d inside {st_full_on, st_sleep} ||
        (mode_d == st_active && pll_en_q);
      pll_bypass <= mode_d == st_active;
      dma_l1_allow <= mode_d inside {st_full_on, st_active};
      async_access_block <= mode_d == st_deep_sleep;
      core_power_on <= mode_d != st_hibernate;
      pins_tristate <= mode_d inside {st_hibernate, st_power_wait};
      core_reset <= mode_d inside {st_hibernate, st_power_wait};
      mode_status <= mode_code(mode_d);
    end
  end

  assign pll_mult = mult_q;

  // regulator wake and self-refresh live on the always-on side
  // a wake source beats a shutdown write in the same cycle
  always_ff @(posedge clk) begin
    if (aon_rst) begin
      external_regulator_wake <= 1'b1;
      sdram_self_refresh <= 1'b0;
      regulator_control_register <= vr_reset_value;
    end else begin
      regulator_control_register <= vr_wr ? vr_data : vr_q;
      if (wake_hit || eth_wake_req) begin
        external_regulator_wake <= 1'b1;
      end else if (vr_wr &&
          vr_data[vr_regulator_switch_rate_field_lsb +: vr_regulator_switch_rate_field_width] == vr_regulator_switch_rate_field_shutdown) begin
        external_regulator_wake <= 1'b0;
      end
      sdram_self_refresh <= sr_hold_q ||
        (mode_q != st_hibernate && mode_d == st_hibernate && vr_q[vr_sdram_cke_low_bit]);
    end
  end

endmodule // power_mode_controller

// >>> logic/pmc_pkg.sv
// Purpose: shared constants and types for the power-mode controller
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: the regulator control register here is a plain port bundle, no bus
package pmc_pkg;

  typedef enum logic [2:0] {
    st_full_on,
    st_active,
    st_sleep,
    st_deep_sleep,
    st_hibernate,
    st_power_wait
  } mode_type;

  // mode codes reported on the status port
  localparam logic [2:0] mode_code_full_on = 3'h0;
  localparam logic [2:0] mode_code_active = 3'h1;
  localparam logic [2:0] mode_code_sleep = 3'h2;
  localparam logic [2:0] mode_code_deep_sleep = 3'h3;
  localparam logic [2:0] mode_code_hibernate = 3'h4;
  localparam logic [2:0] mode_code_power_wait = 3'h5;

  // regulator control register layout
  localparam int vr_width = 8;
  localparam int vr_regulator_switch_rate_field_lsb = 0;
  localparam int vr_regulator_switch_rate_field_width = 2;
  localparam int vr_wake_phy_bit = 2;
  localparam int vr_wake_rtc_bit = 3;
  localparam int vr_wake_reset_bit = 4;
  localparam int vr_sdram_cke_low_bit = 5;
  localparam logic [1:0] vr_regulator_switch_rate_field_shutdown = 2'h0;
  localparam logic [7:0] vr_reset_value = 8'h1f;

  // multiplier field of the clock control
  localparam int mult_width = 6;
  localparam logic [5:0] mult_reset_value = 6'h06;

  // power-good settle time before leaving the wait state
  localparam int power_good_settle_ns = 100;
  localparam int clk_period_ns = 20;
  localparam int power_good_settle_cycles =
    (power_good_settle_ns + clk_period_ns - 1) / clk_period_ns;

endpackage : pmc_pkg

// >>> logic/pmc_retained_reg.sv
// Purpose: retained regulator control register in the always-on domain
// Assumes: clocked by the always-on clock; only the always-on reset clears it
// Notes: core reset and hibernate do not touch this register
`timescale 1ns/1ps
module pmc_retained_reg
  import pmc_pkg::*;
#(
  parameter int width = vr_width,
  parameter logic [vr_width-1:0] reset_value = vr_reset_value
) (
  input wire logic clk,
  input wire logic aon_rst,
  input wire logic wr_en,
  input wire logic [width-1:0] wr_data,
  output logic [width-1:0] value_q
);

  // survives core power removal: no core reset input at all
  always_ff @(posedge clk) begin
    if (aon_rst) begin
      value_q <= reset_value[width-1:0];
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end

endmodule // pmc_retained_reg

// >>> sim/pmc_regulator.sv
// Purpose: external regulator model feeding power good back
// Assumes: ramp counted in clk cycles
// Notes: shutdown drops power good at once, power-up waits for the ramp
`timescale 1ns/1ps
module pmc_regulator #(
  parameter int ramp_cycles = 3
) (
  input wire logic clk,
  input wire logic external_regulator_wake,
  output logic power_good_input_n
);
  int cnt_q;
  // low wake means shut down; high wake powers up
  always_ff @(posedge clk) begin
    if (!external_regulator_wake) cnt_q <= 0;
    else if (cnt_q < ramp_cycles) cnt_q <= cnt_q + 1;
  end
  // a slow ramp makes the device really wait for good supply
  assign power_good_input_n = !(external_regulator_wake && cnt_q >= ramp_cycles);
endmodule // pmc_regulator

// >>> sim/pmc_chk.sv
// Purpose: port-level property checks for the power-mode controller
// Assumes: one clock domain, rst synchronous active high
// Notes: skip bit has no port, so a copy follows its write strobe
`timescale 1ns/1ps
module pmc_chk
  import pmc_pkg::*;
#(
  parameter int settle_cycles = power_good_settle_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pll_skip_wr,
  input wire logic pll_skip_data,
  input wire logic wakeup_event,
  input wire logic rtc_async_irq,
  input wire logic rtc_wake,
  input wire logic reset_pin_n,
  input wire logic phy_interrupt_wake_pin_n,
  input wire logic eth_wake_req,
  input wire logic power_good_input_n,
  input wire logic vr_wr,
  input wire logic [vr_width-1:0] vr_data,
  input wire logic core_clock_en,
  input wire logic system_clock_en,
  input wire logic pll_enable,
  input wire logic pll_bypass,
  input wire logic [mult_width-1:0] pll_mult,
  input wire logic dma_l1_allow,
  input wire logic async_access_block,
  input wire logic core_power_on,
  input wire logic external_regulator_wake,
  input wire logic pins_tristate,
  input wire logic core_reset,
  input wire logic [2:0] mode_status
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic skip_q;
  // the skip bit is lost in hibernate, so the copy forgets it there too
  always_ff @(posedge clk) begin
    if (rst || mode_status == mode_code_hibernate) skip_q <= 1'b0;
    else if (pll_skip_wr) skip_q <= pll_skip_data;
  end
  a_reset_full_on: assert property (
    $fell(rst) |-> mode_status == mode_code_full_on)
    else $error("mode after reset is not full-on");
  a_full_on_pll: assert property (
    mode_status == mode_code_full_on |->
    core_clock_en && system_clock_en && pll_enable && !pll_bypass)
    else $error("full-on clocks wrong");
  a_active_bypass: assert property (
    mode_status == mode_code_active |->
    pll_bypass && core_clock_en && system_clock_en && dma_l1_allow)
    else $error("active clocks wrong");
  a_sleep_clocks: assert property (
    mode_status == mode_code_sleep |->
    !core_clock_en && system_clock_en && pll_enable && !dma_l1_allow)
    else $error("sleep clocks wrong");
  a_deep_clocks: assert property (
    mode_status == mode_code_deep_sleep |->
    !core_clock_en && !system_clock_en && async_access_block)
    else $error("deep sleep clocks wrong");
  a_hib_power_off: assert property (
    mode_status == mode_code_hibernate |->
    !core_power_on && pins_tristate && !system_clock_en)
    else $error("hibernate outputs wrong");
  a_sleep_wake_target: assert property (
    mode_status == mode_code_sleep && wakeup_event |=>
    mode_status == ($past(skip_q) ? mode_code_active : mode_code_full_on))
    else $error("sleep wake target wrong");
  a_deep_rtc_exit: assert property (
    mode_status == mode_code_deep_sleep && rtc_async_irq && reset_pin_n |=>
    mode_status == mode_code_active)
    else $error("deep sleep rtc exit wrong");
  a_deep_pin_exit: assert property (
    mode_status == mode_code_deep_sleep && !reset_pin_n |=>
    mode_status == mode_code_full_on)
    else $error("deep sleep reset exit wrong");
  a_mult_held: assert property (
    mode_status == mode_code_active |=>
    mode_status != mode_code_active || $stable(pll_mult))
    else $error("multiplier changed in active");
  a_shutdown_low: assert property (
    vr_wr && vr_data[vr_regulator_switch_rate_field_lsb +: vr_regulator_switch_rate_field_width] == vr_regulator_switch_rate_field_shutdown && reset_pin_n &&
    phy_interrupt_wake_pin_n && !rtc_wake && !eth_wake_req |=> !external_regulator_wake)
    else $error("regulator wake not dropped");
  a_wait_wake_high: assert property (
    mode_status == mode_code_power_wait |->
    external_regulator_wake && core_reset)
    else $error("power wait outputs wrong");
  a_wait_good: assert property (
    mode_status == mode_code_power_wait && power_good_input_n |=>
    mode_status == mode_code_power_wait)
    else $error("left power wait without power good");
endmodule // pmc_chk

bind power_mode_controller pmc_chk #(.settle_cycles(settle_cycles)) chk (.clk, .rst,
  .pll_skip_wr, .pll_skip_data, .wakeup_event, .rtc_async_irq, .rtc_wake, .reset_pin_n,
  .phy_interrupt_wake_pin_n, .eth_wake_req, .power_good_input_n, .vr_wr, .vr_data,
  .core_clock_en, .system_clock_en, .pll_enable, .pll_bypass, .pll_mult, .dma_l1_allow,
  .async_access_block, .core_power_on, .external_regulator_wake, .pins_tristate,
  .core_reset, .mode_status);

// >>> sim/test_power_mode_controller.sv
// Purpose: directed mode-sequence tests of the power-mode controller
// Assumes: inputs change on the falling clock edge
// Notes: settle count cut to 1; the regulator ramp sets the real wait
`timescale 1ns/1ps
module test_power_mode_controller
  import pmc_pkg::*;
;
  logic clk = 0, rst = 1, aon_rst = 1;
  logic req_active = 0, req_full_on = 0, req_sleep = 0, req_deep_sleep = 0, req_hibernate = 0;
  logic pll_enable_wr = 0, pll_enable_data = 0, pll_skip_wr = 0, pll_skip_data = 0;
  logic mult_wr = 0, vr_wr = 0, wakeup_event = 0, rtc_async_irq = 0, rtc_wake = 0;
  logic reset_pin_n = 1, phy_interrupt_wake_pin_n = 1, eth_wake_req = 0, power_good_input_n;
  logic [mult_width-1:0] mult_data = 6'h00, pll_mult;
  logic [vr_width-1:0] vr_data = 8'h00, regulator_control_register, v;
  logic core_clock_en, system_clock_en, pll_enable, pll_bypass, dma_l1_allow, async_access_block;
  logic core_power_on, external_regulator_wake, pins_tristate, sdram_self_refresh, core_reset;
  logic [2:0] mode_status;
  int n_errors = 0, checks = 0;
  power_mode_controller #(.settle_cycles(1)) DUT (
    .clk, .rst, .aon_rst, .req_active, .req_full_on, .req_sleep, .req_deep_sleep,
    .req_hibernate, .pll_enable_wr, .pll_enable_data, .pll_skip_wr, .pll_skip_data,
    .mult_wr, .mult_data, .vr_wr, .vr_data, .wakeup_event, .rtc_async_irq, .rtc_wake,
    .reset_pin_n, .phy_interrupt_wake_pin_n, .eth_wake_req, .power_good_input_n,
    .core_clock_en, .system_clock_en, .pll_enable, .pll_bypass, .pll_mult, .dma_l1_allow,
    .async_access_block, .core_power_on, .external_regulator_wake, .pins_tristate,
    .sdram_self_refresh, .core_reset, .mode_status, .regulator_control_register
  );
  pmc_regulator reg_model (.clk, .external_regulator_wake, .power_good_input_n);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask
  task tick;
    @(negedge clk);
  endtask
  task automatic go(input logic [4:0] r);
    {req_hibernate, req_deep_sleep, req_sleep, req_full_on, req_active} = r;
    tick;
    {req_hibernate, req_deep_sleep, req_sleep, req_full_on, req_active} = 5'h00;
    tick;
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    {pll_enable_data, pll_skip_data, mult_data, vr_data} = {d[0], d[0], d[5:0], d};
    {vr_wr, mult_wr, pll_skip_wr, pll_enable_wr} = 4'h1 << k;
    tick;
    {vr_wr, mult_wr, pll_skip_wr, pll_enable_wr} = 4'h0;
    tick;
  endtask
  task automatic st(input logic [2:0] m, input logic [1:0] c);
    chk("mode", {5'h00, m}, {5'h00, mode_status});
    chk("clocks", {6'h00, c}, {6'h00, core_clock_en, system_clock_en});
  endtask
  // one wake source at a time; 4 means none
  task automatic src(input int k);
    phy_interrupt_wake_pin_n = k != 0;
    rtc_wake = k == 1;
    reset_pin_n = k != 2;
    eth_wake_req = k == 3;
  endtask
  task end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (4) tick;
    rst = 0;
    aon_rst = 0;
    tick;
    st(mode_code_full_on, 2'h3);
    chk("pll", 8'h02, {6'h00, pll_enable, pll_bypass});
    chk("vr", vr_reset_value, regulator_control_register);
    go(5'h01);
    chk("pll", 8'h03, {6'h00, pll_enable, pll_bypass});
    chk("dma", 8'h01, {7'h00, dma_l1_allow});
    wr(2, 8'h0a);
    chk("mult", {2'h0, mult_reset_value}, {2'h0, pll_mult});
    go(5'h02);
    chk("mult", 8'h0a, {2'h0, pll_mult});
    go(5'h01);
    wr(0, 8'h00);
    chk("pll", 8'h01, {6'h00, pll_enable, pll_bypass});
    go(5'h02);
    st(mode_code_active, 2'h3);
    wr(0, 8'h01);
    go(5'h02);
    st(mode_code_full_on, 2'h3);
    for (int s = 0; s < 2; s++) begin
      wr(1, 8'(s));
      go(5'h04);
      st(mode_code_sleep, 2'h1);
      chk("dma", 8'h00, {7'h00, dma_l1_allow});
      wakeup_event = 1;
      tick;
      wakeup_event = 0;
      st(s ? mode_code_active : mode_code_full_on, 2'h3);
    end
    for (int k = 0; k < 2; k++) begin
      go(5'h08);
      st(mode_code_deep_sleep, 2'h0);
      chk("block", 8'h01, {7'h00, async_access_block});
      {rtc_async_irq, reset_pin_n} = k ? 2'b00 : 2'b11;
      tick;
      {rtc_async_irq, reset_pin_n} = 2'b01;
      st(k ? mode_code_full_on : mode_code_active, 2'h3);
    end
    // sources 0..3: phy pin, rtc, reset pin, ethernet; odd passes leave sdram free
    for (int s = 0; s < 4; s++) begin
      v = (s % 2 ? 8'h00 : 8'h20) | (s < 3 ? 8'h04 << s : 8'h00);
      wr(3, v);
      chk("wake", 8'h00, {7'h00, external_regulator_wake});
      go(5'h10);
      st(mode_code_hibernate, 2'h0);
      chk("off", 8'h02, {6'h00, pins_tristate, core_power_on});
      chk("sdram", s % 2 ? 8'h00 : 8'h01, {7'h00, sdram_self_refresh});
      src((s + 1) % 3);
      tick;
      st(mode_code_hibernate, 2'h0);
      src(s);
      tick;
      src(4);
      chk("wait", 8'h0b, {4'h0, mode_status, external_regulator_wake});
      for (int i = 0; i < 40 && mode_status !== mode_code_full_on; i++) tick;
      st(mode_code_full_on, 2'h3);
      chk("reset", 8'h00, {7'h00, core_reset});
      chk("vr", v, regulator_control_register);
      // self-refresh is lifted two edges after full-on
      repeat (2) tick;
      chk("sdram", 8'h00, {7'h00, sdram_self_refresh});
    end
    end_sim;
  end
endmodule // test_power_mode_controller
